/* prsl_defs.vh */
// Purpose: constants for the reset, strap and indicator block
// Assumes: 200 MHz core clock, reset time below in ns, blink time in ms
// Notes: header holds definitions only
`ifndef PRSL_DEFS_VH
`define PRSL_DEFS_VH

// clock rate and reset timing
`define PRSL_CLK_MHZ 200
`define PRSL_RST_MIN_NS 1000
`define PRSL_RST_MIN_CYC ((`PRSL_RST_MIN_NS * `PRSL_CLK_MHZ + 999) / 1000)

// register offsets
`define PRSL_REG_CTRL 4'h0
`define PRSL_REG_STAT 4'h4
`define PRSL_REG_CFG 4'h8

// control and config register fields
`define PRSL_CTRL_ADDR_LSB 0
`define PRSL_CTRL_ISO_BIT 5
`define PRSL_CFG_MODE_BIT 0

// reset values and strap defaults
`define PRSL_ADDR_PULL 5'h01
`define PRSL_CFG_RST 32'h00000000

// indicator mode codes
`define PRSL_MODE1 1'b0
`define PRSL_MODE2 1'b1

// blink timing
`define PRSL_BLINK_MS 50
`define PRSL_BLINK_CYC (`PRSL_BLINK_MS * 1000 * `PRSL_CLK_MHZ)

`endif

/* prsl_stretch.v */
// Purpose: stretches short activity into a blink of fixed length
// Assumes: synchronous activity input
// Notes: retriggers only after the current blink ends
`include "prsl_defs.vh"

module prsl_stretch #(
  parameter CNT_W = 24,
  parameter [CNT_W-1:0] LEN = 24'd10000000
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire act,
  output reg blink
);

  reg [CNT_W-1:0] cnt;

  // ---------------------------------------------------------------
  // stretcher
  // ---------------------------------------------------------------
  // one blink lasts LEN cycles, load cycle included: blink high (lamp
  // dark) for the first half, low for the second, so a glimmer of
  // activity still gives a visible flash
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= {CNT_W{1'b0}};
      blink <= 1'b0;
    end else if (ce) begin
      if (cnt != {CNT_W{1'b0}}) begin
        cnt <= cnt - {{(CNT_W-1){1'b0}}, 1'b1};
        blink <= (cnt > (LEN >> 1));
      end else if (act) begin
        cnt <= LEN - {{(CNT_W-1){1'b0}}, 1'b1};
        blink <= 1'b1;
      end else begin
        blink <= 1'b0;
      end
    end
  end

endmodule // prsl_stretch

/* prsl_rstgen.v */
// Purpose: qualifies the low-active reset pin and gives a reset phase
// Assumes: pin synchronous to clk
// Notes: short glitches under the least width are ignored
`include "prsl_defs.vh"

module prsl_rstgen #(
  parameter [7:0] MIN_CYC = 8'd200
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire reset_pin_n,
  output reg in_reset,
  output reg release_pulse
);

  reg [7:0] low_cnt;

  // ---------------------------------------------------------------
  // width qualifier
  // ---------------------------------------------------------------
  // reset phase only starts once the pin has been low long enough
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 8'h00;
      in_reset <= 1'b1;
      release_pulse <= 1'b0;
    end else if (ce) begin
      release_pulse <= 1'b0;
      if (!reset_pin_n) begin
        if (low_cnt != MIN_CYC)
          low_cnt <= low_cnt + 8'h01;
        else
          in_reset <= 1'b1;
      end else begin
        low_cnt <= 8'h00;
        if (in_reset) begin
          in_reset <= 1'b0;
          release_pulse <= 1'b1;
        end
      end
    end
  end

endmodule // prsl_rstgen

/* prsl_top.v */
// Purpose: reset, strap sampling and indicator logic of a 10/100 PHY
// Assumes: all pins synchronous to clk; link, speed, activity from core
// Notes: straps read through pins whose enable is low while driving
`include "prsl_defs.vh"

module prsl_top #(
  parameter BLINK_CYC = `PRSL_BLINK_CYC,
  parameter RST_CYC = `PRSL_RST_MIN_CYC
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire reset_pin_n,
  input wire rmii_mode,
  input wire link_good,
  input wire speed_100,
  input wire tx_active,
  input wire rx_active,
  input wire addr_strap_bit0_in,
  input wire [3:0] addr_strap_upper_bits_in,
  input wire alt_bit0,
  input wire [3:0] alt_upper_bits,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg addr_strap_bit0_out,
  output reg addr_strap_bit0_oe_n,
  output reg [3:0] addr_strap_upper_bits_out,
  output reg [3:0] addr_strap_upper_bits_oe_n,
  output reg link_indicator,
  output reg speed_indicator,
  output reg isolate,
  output reg core_reset
);

  wire in_reset;
  wire release_pulse;
  wire blink;
  reg [4:0] phy_addr;
  reg iso_strap;
  reg led_mode;
  reg [4:0] strap_sample;
  reg next_link_ind;

  // ---------------------------------------------------------------
  // reset qualification
  // ---------------------------------------------------------------
  prsl_rstgen #(
    .MIN_CYC(RST_CYC[7:0])
  ) u_rstgen (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .reset_pin_n(reset_pin_n),
    .in_reset(in_reset),
    .release_pulse(release_pulse)
  );

  // ---------------------------------------------------------------
  // activity stretcher
  // ---------------------------------------------------------------
  prsl_stretch #(
    .CNT_W(24),
    .LEN(BLINK_CYC[23:0])
  ) u_stretch (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .act(tx_active | rx_active),
    .blink(blink)
  );

  // ---------------------------------------------------------------
  // strap sampling
  // ---------------------------------------------------------------
  // pins are released during reset so pulls set the level; the last
  // sample before release is the one that counts
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_sample <= `PRSL_ADDR_PULL;
    end else if (ce && in_reset) begin
      strap_sample <= {addr_strap_upper_bits_in, addr_strap_bit0_in};
    end
  end

  // pin drivers: inputs only while in reset, then alternate roles
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_strap_bit0_oe_n <= 1'b1;
      addr_strap_upper_bits_oe_n <= 4'hf;
      addr_strap_bit0_out <= 1'b0;
      addr_strap_upper_bits_out <= 4'h0;
    end else if (ce) begin
      addr_strap_bit0_oe_n <= in_reset;
      addr_strap_upper_bits_oe_n <= {4{in_reset}};
      addr_strap_bit0_out <= in_reset ? 1'b0 : alt_bit0;
      addr_strap_upper_bits_out <= in_reset ? 4'h0 : alt_upper_bits;
    end
  end

  // ---------------------------------------------------------------
  // control state
  // ---------------------------------------------------------------
  // led_mode and iso_strap return to defaults for the whole reset phase; the
  // address field keeps its value and takes the fresh strap at release
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      phy_addr <= `PRSL_ADDR_PULL;
      iso_strap <= 1'b0;
      led_mode <= `PRSL_MODE1;
    end else if (ce) begin
      if (in_reset) begin
        led_mode <= `PRSL_MODE1;
        iso_strap <= 1'b0;
      end else if (release_pulse) begin
        phy_addr <= strap_sample;
        iso_strap <= (strap_sample == 5'h00);
      end else if (reg_wr && reg_addr == `PRSL_REG_CTRL) begin
        phy_addr <= reg_wdata[4:0];
      end else if (reg_wr && reg_addr == `PRSL_REG_CFG) begin
        led_mode <= reg_wdata[`PRSL_CFG_MODE_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // register reads
  // ---------------------------------------------------------------
  // data valid only in the cycle after the strobe, zero otherwise
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (ce) begin
      if (reg_rd) begin
        case (reg_addr)
          `PRSL_REG_CTRL: reg_rdata <= {26'h0, iso_strap, phy_addr};
          `PRSL_REG_STAT: reg_rdata <= {27'h0, rmii_mode, in_reset,
            speed_100, link_good, blink};
          `PRSL_REG_CFG: reg_rdata <= {31'h0, led_mode};
          default: reg_rdata <= 32'h00000000;
        endcase
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  // ---------------------------------------------------------------
  // indicators
  // ---------------------------------------------------------------
  always @* begin
    case (led_mode)
      `PRSL_MODE1: next_link_ind = link_good;
      `PRSL_MODE2: next_link_ind = link_good & ~blink;
      default: next_link_ind = 1'b0;
    endcase
  end

  // indicators dark during reset since the pins act as straps then
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      link_indicator <= 1'b0;
      speed_indicator <= 1'b0;
      isolate <= 1'b0;
      core_reset <= 1'b1;
    end else if (ce) begin
      link_indicator <= ~in_reset & next_link_ind;
      speed_indicator <= ~in_reset & speed_100;
      isolate <= iso_strap;
      core_reset <= in_reset;
    end
  end

endmodule // prsl_top

/* prsl_properties.sv */
// Purpose: port checker for the reset, strap and indicator block
// Assumes: ce held high by the bench
// Notes: bound into prsl_top below
module prsl_props #(
  parameter BLINK_CYC = 20,
  parameter RST_CYC = 4
) (
  input wire clk,
  input wire rst,
  input wire reset_pin_n,
  input wire link_good,
  input wire speed_100,
  input wire tx_active,
  input wire rx_active,
  input wire addr_strap_bit0_oe_n,
  input wire [3:0] addr_strap_upper_bits_oe_n,
  input wire link_indicator,
  input wire speed_indicator,
  input wire isolate,
  input wire core_reset
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  reg [7:0] low_cnt;
  reg [31:0] quiet;
  // run lengths of pin low and of an idle good link; low_cnt saturates
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt <= 8'h00;
      quiet <= 32'h0;
    end else begin
      low_cnt <= reset_pin_n ? 8'h00 : low_cnt + (low_cnt != 8'hff);
      quiet <= (!link_good || tx_active || rx_active || core_reset) ?
        32'h0 : quiet + 32'h1;
    end
  end
  // out of reset and no new reset on its way
  sequence s_run;
    !core_reset && $past(reset_pin_n);
  endsequence
  a_speed_follow: assert property (
    s_run |-> speed_indicator == $past(speed_100))
    else $error("speed indicator does not follow the rate");
  a_link_cause: assert property (
    link_indicator |-> $past(link_good))
    else $error("link indicator on without a good link");
  a_link_quiet_on: assert property (
    quiet > BLINK_CYC + 4 |-> link_indicator)
    else $error("link indicator off on an idle good link");
  a_straps_input: assert property (
    core_reset && $past(!reset_pin_n) |->
    &addr_strap_upper_bits_oe_n && addr_strap_bit0_oe_n)
    else $error("strap pin driven during reset");
  a_straps_drive: assert property (
    s_run |-> addr_strap_upper_bits_oe_n == 4'h0 && !addr_strap_bit0_oe_n)
    else $error("strap pin not driven after reset");
  a_iso_hold: assert property (
    !core_reset && $past(!core_reset, 3) && reset_pin_n &&
    $past(reset_pin_n) |-> $stable(isolate))
    else $error("isolate changed outside reset");
  a_reset_min: assert property (
    $rose(core_reset) |-> $past(low_cnt) >= RST_CYC)
    else $error("reset taken from a short pulse");
  a_reset_enter: assert property (
    low_cnt > RST_CYC + 3 |-> core_reset)
    else $error("long reset pulse not taken");
endmodule // prsl_props

bind prsl_top prsl_props #(.BLINK_CYC(BLINK_CYC), .RST_CYC(RST_CYC)) u_props (
  .clk(clk), .rst(rst), .reset_pin_n(reset_pin_n), .link_good(link_good),
  .speed_100(speed_100), .tx_active(tx_active), .rx_active(rx_active),
  .addr_strap_bit0_oe_n(addr_strap_bit0_oe_n),
  .addr_strap_upper_bits_oe_n(addr_strap_upper_bits_oe_n),
  .link_indicator(link_indicator), .speed_indicator(speed_indicator),
  .isolate(isolate), .core_reset(core_reset));

/* prsl_board.sv */
// Purpose: board side of the strap pins: resistors and weak pulls
// Assumes: oe_n low means the device drives the pin
// Notes: a driving device wins over any resistor
module prsl_board (
  input wire logic strap_en,
  input wire logic [4:0] strap_val,
  input wire logic bit0_out,
  input wire logic bit0_oe_n,
  input wire logic [3:0] upper_out,
  input wire logic [3:0] upper_oe_n,
  output wire logic bit0_in,
  output wire logic [3:0] upper_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // unstrapped, bit 0 pulls up and bits 4:1 pull down
  assign bit0_in = !bit0_oe_n ? bit0_out : (strap_en ? strap_val[0] : 1'b1);
  assign upper_in = (~upper_oe_n & upper_out) |
    (upper_oe_n & (strap_en ? strap_val[4:1] : 4'h0));
endmodule // prsl_board

/* prsl_bench.sv */
// Purpose: self-checking bench for the reset, strap and indicator block
// Assumes: 200 MHz clock, shortened blink and reset counts
// Notes: ce is held high throughout
module prsl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BLINK = 20;
  localparam int RSTC = 4;
  logic clk = 0, rst = 1, pin_n = 1, link = 0, spd = 0, tx = 0, rx = 0;
  logic rmii = 0, abit0 = 0, wr = 0, rd = 0, sen = 0;
  logic [3:0] aup = 0, addr = 0;
  logic [4:0] sval = 0;
  logic [31:0] wdata = 0, d;
  wire [31:0] rdata;
  wire b0o, b0oe, b0i, lnk_i, spd_i, iso, crst;
  wire [3:0] upo, upoe, upi;
  int miscompares = 0, compares = 0, lows;

  prsl_top #(.BLINK_CYC(BLINK), .RST_CYC(RSTC)) u_prsl_top (
    .clk(clk), .rst(rst), .ce(1'b1), .reset_pin_n(pin_n), .rmii_mode(rmii),
    .link_good(link), .speed_100(spd), .tx_active(tx), .rx_active(rx),
    .addr_strap_bit0_in(b0i), .addr_strap_upper_bits_in(upi),
    .alt_bit0(abit0), .alt_upper_bits(aup), .reg_addr(addr),
    .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
    .addr_strap_bit0_out(b0o), .addr_strap_bit0_oe_n(b0oe),
    .addr_strap_upper_bits_out(upo), .addr_strap_upper_bits_oe_n(upoe),
    .link_indicator(lnk_i), .speed_indicator(spd_i), .isolate(iso),
    .core_reset(crst));
  prsl_board u_prsl_board (.strap_en(sen), .strap_val(sval), .bit0_out(b0o),
    .bit0_oe_n(b0oe), .upper_out(upo), .upper_oe_n(upoe), .bit0_in(b0i),
    .upper_in(upi));

  always #2.5 clk = ~clk; // one board reference

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  // pin held low for n sampling edges, then time to settle
  task automatic pin_rst(input int n);
    @(posedge clk);
    pin_n <= 1'b0;
    repeat (n) @(posedge clk);
    pin_n <= 1'b1;
    repeat (8) @(posedge clk);
  endtask
  task automatic stop_test;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // the whole sequence needs about 1300 cycles
  initial begin
    #(20000 * 5);
    miscompares++;
    stop_test;
  end

  initial begin
    void'($urandom(32'ha0d71353));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rd_reg(4'h8, 32'h0);
    rd_reg(4'hc, 32'h0);
    sen <= 1'b1;
    for (int a = 0; a < 32; a++) begin
      sval <= a[4:0];
      {abit0, aup} <= $urandom;
      pin_rst(RSTC + 3);
      rd_reg(4'h0, {26'h0, a == 0, a[4:0]});
      chk(iso, a == 0);
      chk({upo, b0o}, {aup, abit0});
    end
    sen <= 1'b0;
    pin_rst(RSTC + 3);
    rd_reg(4'h0, 32'h01);
    d = $urandom;
    wr_reg(4'h0, d);
    rd_reg(4'h0, {27'h0, d[4:0]});
    wr_reg(4'h0, 32'h0);
    wr_reg(4'h8, 32'h1);
    rd_reg(4'h0, 32'h0);
    chk(iso, 1'b0);
    pin_rst(RSTC);
    rd_reg(4'h8, 32'h1);
    pin_rst(RSTC + 6);
    rd_reg(4'h0, 32'h01);
    rd_reg(4'h8, 32'h0);
    // both modes, one pulse of tx or rx each time
    for (int i = 0; i < 4; i++) begin
      wr_reg(4'h8, i >> 1);
      link <= 1'b1;
      spd <= i[0];
      repeat (BLINK + 8) @(posedge clk);
      {tx, rx} <= i[0] ? 2'b10 : 2'b01;
      @(posedge clk);
      {tx, rx} <= 2'b00;
      lows = 0;
      repeat (BLINK + 8) begin
        @(negedge clk);
        lows += (lnk_i === 1'b0);
      end
      chk(lows, i[1] ? BLINK / 2 : 0);
      chk(spd_i, i[0]);
    end
    @(posedge clk);
    rmii <= 1'b1;
    rd_reg(4'h4, 32'h16);
    // random status traffic for the port checker
    repeat (400) begin
      @(posedge clk);
      {link, spd, rmii} <= $urandom;
      tx <= ($urandom % 16) == 0;
      rx <= ($urandom % 16) == 0;
    end
    stop_test;
  end
endmodule // prsl_bench
